// file: shared/yuv_rgb_conv_pkg.sv
package yuv_rgb_conv_pkg;

    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int WORD_W = 16;
    localparam int FIFO_DEPTH = 8;

    // Register indices; byte address is four times the index
    localparam logic [ADDR_W-1:0] IDX_MODE   = 12'h240;
    localparam logic [ADDR_W-1:0] IDX_FIXED  = 12'h24A;
    localparam logic [ADDR_W-1:0] IDX_STATUS = 12'h260;
    localparam logic [ADDR_W-1:0] ADDR_MODE   = 12'h900;
    localparam logic [ADDR_W-1:0] ADDR_FIXED  = 12'h928;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 12'h980;

    localparam logic [WORD_W-1:0] MODE_RESET  = 16'h0405;
    localparam logic [WORD_W-1:0] MODE_MASK   = 16'hFD77;
    localparam logic [WORD_W-1:0] FIXED_RESET = 16'h0000;

    localparam int BIT_BYPASS  = 15;
    localparam int BIT_CONVRST = 14;
    localparam int FIX_HI      = 13;
    localparam int FIX_LO      = 12;
    localparam int DEPTH_HI    = 11;
    localparam int DEPTH_LO    = 10;
    localparam int BIT_PACKING = 8;

    localparam logic [1:0] FIX_U    = 2'h1;
    localparam logic [1:0] FIX_V    = 2'h2;
    localparam logic [1:0] DEPTH_16 = 2'h0;

    // Fixed-point colour coefficients, scaled by 2^COEF_SHIFT
    localparam int COEF_SHIFT = 8;
    localparam logic signed [11:0] COEF_RV = 12'sh167;
    localparam logic signed [11:0] COEF_GU = 12'sh058;
    localparam logic signed [11:0] COEF_GV = 12'sh0B7;
    localparam logic signed [11:0] COEF_BU = 12'sh1C6;
    localparam logic signed [9:0]  CHROMA_MID = 10'sh080;
    localparam logic signed [19:0] PIX_MAX    = 20'sh000FF;

    typedef struct packed {
        logic [7:0] y0;
        logic [7:0] y1;
        logic [7:0] u;
        logic [7:0] v;
    } yuv_pair_type;

    typedef struct packed {
        logic             bypass;
        logic             conv_rst;
        logic [1:0]       fix_sel;
        logic [1:0]       depth;
        logic             packing;
    } mode_type;

    typedef enum logic [1:0] {FMT_IDLE, FMT_FIRST, FMT_SECOND} fmt_state_type;

endpackage

// file: hw/yuv_rgb_conv_ctrl.sv
`timescale 1ns/1ps

module word_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input  wire logic             core_clk,  // System clock
    input  wire logic             clr,       // Synchronous clear
    input  wire logic             in_valid,  // Write request
    output logic                  in_ready,  // Space available
    input  wire logic [WIDTH-1:0] in_data,   // Write data
    output logic                  out_valid, // Head word valid
    input  wire logic             out_ready, // Consumer takes head
    output logic [WIDTH-1:0]      out_data,  // Head word
    output logic [$clog2(DEPTH):0] level     // Words held in array
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [PW-1:0]    wr_ptr_ff;
    logic [PW-1:0]    nxt_wr_ptr;
    logic [PW-1:0]    rd_ptr_ff;
    logic [PW-1:0]    nxt_rd_ptr;
    logic [PW:0]      count_ff;
    logic [PW:0]      nxt_count;
    logic             ovalid_ff;
    logic             nxt_ovalid;
    logic [WIDTH-1:0] odata_ff;
    logic [WIDTH-1:0] nxt_odata;
    logic             push;
    logic             pop;

    assign in_ready  = (count_ff != (PW+1)'(DEPTH));
    assign out_valid = ovalid_ff;
    assign out_data  = odata_ff;
    assign level     = count_ff;

    always_comb
    begin
        push       = in_valid && in_ready;
        pop        = (count_ff != '0) && (!ovalid_ff || out_ready);
        nxt_wr_ptr = push ? PW'(wr_ptr_ff + 1'b1) : wr_ptr_ff;
        nxt_rd_ptr = pop ? PW'(rd_ptr_ff + 1'b1) : rd_ptr_ff;
        nxt_count  = count_ff;
        if (push && !pop)
            nxt_count = (PW+1)'(count_ff + 1'b1);
        else if (pop && !push)
            nxt_count = (PW+1)'(count_ff - 1'b1);
        nxt_ovalid = ovalid_ff && !out_ready;
        nxt_odata  = odata_ff;
        if (pop)
        begin
            nxt_ovalid = 1'b1;
            nxt_odata  = mem_ff[rd_ptr_ff];
        end
        if (clr)
        begin
            nxt_wr_ptr = '0;
            nxt_rd_ptr = '0;
            nxt_count  = '0;
            nxt_ovalid = 1'b0;
        end
    end

    always_ff @(posedge core_clk)
    begin
        wr_ptr_ff <= nxt_wr_ptr;
        rd_ptr_ff <= nxt_rd_ptr;
        count_ff  <= nxt_count;
        ovalid_ff <= nxt_ovalid;
        odata_ff  <= nxt_odata;
        if (push && !clr)
            mem_ff[wr_ptr_ff] <= in_data;
    end
endmodule

module yuv_rgb_conv_ctrl (
    input  wire logic                                   core_clk,          // 25 MHz clock
    input  wire logic                                   sys_rst,           // Sync reset, high
    input  wire logic [yuv_rgb_conv_pkg::ADDR_W-1:0]    avs_address,       // Byte address
    input  wire logic                                   avs_read,          // Read request
    input  wire logic                                   avs_write,         // Write request
    input  wire logic [yuv_rgb_conv_pkg::DATA_W-1:0]    avs_writedata,     // Write data
    input  wire logic [3:0]                             avs_byteenable,    // Byte lanes
    output logic [yuv_rgb_conv_pkg::DATA_W-1:0]         avs_readdata,      // Read data
    output logic                                        avs_waitrequest,   // Stall
    input  wire logic                                   pix_valid,         // Pixel pair valid
    output logic                                        pix_ready,         // Pair accepted
    input  wire yuv_rgb_conv_pkg::yuv_pair_type         pix_data,          // Two pixels, shared chroma
    output logic                                        mem_valid,         // Output word valid
    input  wire logic                                   mem_ready,         // Memory side takes word
    output logic [yuv_rgb_conv_pkg::WORD_W-1:0]         mem_data           // Output word
);
    localparam int LW = $clog2(yuv_rgb_conv_pkg::FIFO_DEPTH) + 1;

    // Register file and bus slave
    logic [15:0] mode_ff;
    logic [15:0] nxt_mode;
    logic [15:0] fixed_ff;
    logic [15:0] nxt_fixed;
    logic        wait_ff;
    logic        nxt_wait;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic [15:0] wmask;
    logic [LW-1:0] fifo_level;

    yuv_rgb_conv_pkg::mode_type mode;
    logic conv_clr;

    // One driver for the whole struct rather than one per field
    assign mode = '{bypass:   mode_ff[yuv_rgb_conv_pkg::BIT_BYPASS],
                    conv_rst: mode_ff[yuv_rgb_conv_pkg::BIT_CONVRST],
                    fix_sel:  mode_ff[yuv_rgb_conv_pkg::FIX_HI:yuv_rgb_conv_pkg::FIX_LO],
                    depth:    mode_ff[yuv_rgb_conv_pkg::DEPTH_HI:yuv_rgb_conv_pkg::DEPTH_LO],
                    packing:  mode_ff[yuv_rgb_conv_pkg::BIT_PACKING]};
    assign conv_clr      = sys_rst || mode.conv_rst;

    assign avs_waitrequest = wait_ff;
    assign avs_readdata    = rdata_ff;

    logic [1:0] fmt_state_bits;

    always_comb
    begin
        nxt_mode  = mode_ff;
        nxt_fixed = fixed_ff;
        nxt_wait  = 1'b1;
        nxt_rdata = rdata_ff;
        wmask     = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
        if ((avs_read || avs_write) && wait_ff)
        begin
            // One stall cycle, then the request completes
            nxt_wait  = 1'b0;
            nxt_rdata = '0;
            if (avs_read)
            begin
                case (avs_address)
                    yuv_rgb_conv_pkg::ADDR_MODE:   nxt_rdata = {16'h0000, mode_ff};
                    yuv_rgb_conv_pkg::ADDR_FIXED:  nxt_rdata = {16'h0000, fixed_ff};
                    yuv_rgb_conv_pkg::ADDR_STATUS: nxt_rdata = {16'h0000, 5'h00, fmt_state_bits, conv_clr, 4'h0, LW'(fifo_level)};
                    default:                       nxt_rdata = '0;
                endcase
            end
        end
        if (avs_write && !wait_ff)
        begin
            // Converter reset leaves these registers alone
            if (avs_address == yuv_rgb_conv_pkg::ADDR_MODE)
                nxt_mode = ((mode_ff & ~wmask) | (avs_writedata[15:0] & wmask))
                           & yuv_rgb_conv_pkg::MODE_MASK;
            if (avs_address == yuv_rgb_conv_pkg::ADDR_FIXED)
                nxt_fixed = (fixed_ff & ~wmask) | (avs_writedata[15:0] & wmask);
        end
        if (sys_rst)
        begin
            nxt_mode  = yuv_rgb_conv_pkg::MODE_RESET;
            nxt_fixed = yuv_rgb_conv_pkg::FIXED_RESET;
            nxt_wait  = 1'b1;
            nxt_rdata = '0;
        end
    end

    always_ff @(posedge core_clk)
    begin
        mode_ff  <= nxt_mode;
        fixed_ff <= nxt_fixed;
        wait_ff  <= nxt_wait;
        rdata_ff <= nxt_rdata;
    end

    // Colour conversion helpers
    function automatic logic [7:0] sat8(input logic signed [19:0] x);
        logic [7:0] r;
        r = x[7:0];
        if (x < 0)
            r = 8'h00;
        else if (x > yuv_rgb_conv_pkg::PIX_MAX)
            r = 8'hFF;
        return r;
    endfunction

    function automatic logic [15:0] to_rgb565(input logic [7:0] y, input logic [7:0] u, input logic [7:0] v);
        logic signed [9:0]  du;
        logic signed [9:0]  dv;
        logic signed [19:0] yy;
        logic [7:0]         r;
        logic [7:0]         g;
        logic [7:0]         b;
        du = $signed({2'b00, u}) - yuv_rgb_conv_pkg::CHROMA_MID;
        dv = $signed({2'b00, v}) - yuv_rgb_conv_pkg::CHROMA_MID;
        yy = $signed({12'h000, y});
        r  = sat8(yy + ((yuv_rgb_conv_pkg::COEF_RV * dv) >>> yuv_rgb_conv_pkg::COEF_SHIFT));
        g  = sat8(yy - ((yuv_rgb_conv_pkg::COEF_GU * du + yuv_rgb_conv_pkg::COEF_GV * dv)
                        >>> yuv_rgb_conv_pkg::COEF_SHIFT));
        b  = sat8(yy + ((yuv_rgb_conv_pkg::COEF_BU * du) >>> yuv_rgb_conv_pkg::COEF_SHIFT));
        return {r[7:3], g[7:2], b[7:3]};
    endfunction

    // Formatter: one pixel pair in, two words out
    yuv_rgb_conv_pkg::fmt_state_type state_ff;
    yuv_rgb_conv_pkg::fmt_state_type nxt_state;
    yuv_rgb_conv_pkg::yuv_pair_type  pair_ff;
    yuv_rgb_conv_pkg::yuv_pair_type  nxt_pair;
    logic        in_rdy_ff;
    logic        nxt_in_rdy;
    logic [15:0] word_first;
    logic [15:0] word_second;
    logic [15:0] push_data;
    logic        push_valid;
    logic        push_ready;
    logic        take;

    assign pix_ready      = in_rdy_ff;
    assign fmt_state_bits = state_ff;

    always_comb
    begin
        // Chroma substitution sits ahead of both bypass and conversion paths
        nxt_pair = pair_ff;
        take     = pix_valid && in_rdy_ff;
        if (take)
        begin
            nxt_pair = pix_data;
            if (mode.fix_sel[0])
                nxt_pair.u = fixed_ff[15:8];
            if (mode.fix_sel[1])
                nxt_pair.v = fixed_ff[7:0];
        end
        if (mode.bypass)
        begin
            // Packing only matters here; conversion ignores it
            if (mode.packing)
            begin
                word_first  = {pair_ff.y0, pair_ff.u};
                word_second = {pair_ff.y1, pair_ff.v};
            end
            else
            begin
                word_first  = {pair_ff.v, pair_ff.y1};
                word_second = {pair_ff.u, pair_ff.y0};
            end
        end
        else
        begin
            // Every depth encoding emits 16 bpp words; others have no defined packing
            word_first  = to_rgb565(pair_ff.y0, pair_ff.u, pair_ff.v);
            word_second = to_rgb565(pair_ff.y1, pair_ff.u, pair_ff.v);
        end
        push_valid = (state_ff != yuv_rgb_conv_pkg::FMT_IDLE);
        push_data  = (state_ff == yuv_rgb_conv_pkg::FMT_SECOND) ? word_second : word_first;
        nxt_state  = state_ff;
        case (state_ff)
            yuv_rgb_conv_pkg::FMT_IDLE:
                if (take)
                    nxt_state = yuv_rgb_conv_pkg::FMT_FIRST;
            yuv_rgb_conv_pkg::FMT_FIRST:
                if (push_ready)
                    nxt_state = yuv_rgb_conv_pkg::FMT_SECOND;
            yuv_rgb_conv_pkg::FMT_SECOND:
                if (push_ready)
                    nxt_state = yuv_rgb_conv_pkg::FMT_IDLE;
            default:
                nxt_state = yuv_rgb_conv_pkg::FMT_IDLE;
        endcase
        nxt_in_rdy = (nxt_state == yuv_rgb_conv_pkg::FMT_IDLE);
        if (conv_clr)
        begin
            nxt_state  = yuv_rgb_conv_pkg::FMT_IDLE;
            nxt_in_rdy = 1'b0;
        end
    end

    always_ff @(posedge core_clk)
    begin
        state_ff  <= nxt_state;
        pair_ff   <= nxt_pair;
        in_rdy_ff <= nxt_in_rdy;
    end

    // Words queued toward memory; back-pressure stalls the formatter
    word_fifo #(
        .WIDTH (yuv_rgb_conv_pkg::WORD_W),
        .DEPTH (yuv_rgb_conv_pkg::FIFO_DEPTH)
    ) out_fifo (
        .core_clk  (core_clk),
        .clr       (conv_clr),
        .in_valid  (push_valid),
        .in_ready  (push_ready),
        .in_data   (push_data),
        .out_valid (mem_valid),
        .out_ready (mem_ready),
        .out_data  (mem_data),
        .level     (fifo_level)
    );
endmodule

// file: testbench/yuv_rgb_conv_ctrl_assertions.sv
`timescale 1ns/1ps
module conv_ctrl_checker (
    input wire logic        core_clk,        // Clock
    input wire logic        sys_rst,         // Reset
    input wire logic [11:0] avs_address,     // Address
    input wire logic        avs_read,        // Read
    input wire logic        avs_write,       // Write
    input wire logic [31:0] avs_writedata,   // Write data
    input wire logic [3:0]  avs_byteenable,  // Lanes
    input wire logic [31:0] avs_readdata,    // Read data
    input wire logic        avs_waitrequest, // Stall
    input wire logic        pix_valid,       // Pair offered
    input wire logic        pix_ready,       // Pair taken
    input wire logic        mem_valid,       // Word offered
    input wire logic        mem_ready,       // Word taken
    input wire logic [15:0] mem_data         // Word
);
    logic [15:0] mode_ff;
    logic [15:0] nxt_mode;
    logic        wr_mode;
    logic        rd_done;
    logic        rd_mode;
    logic        mapped;
    assign wr_mode = avs_write && !avs_waitrequest && avs_address == yuv_rgb_conv_pkg::ADDR_MODE;
    assign rd_done = avs_read && !avs_waitrequest;
    assign rd_mode = rd_done && avs_address == yuv_rgb_conv_pkg::ADDR_MODE;
    assign mapped  = avs_address inside {12'h900, 12'h928, 12'h980};
    always_comb
    begin
        nxt_mode = mode_ff;
        if (wr_mode && avs_byteenable[0])
            nxt_mode[7:0] = avs_writedata[7:0];
        if (wr_mode && avs_byteenable[1])
            nxt_mode[15:8] = avs_writedata[15:8];
    end
    always_ff @(posedge core_clk)
        mode_ff <= sys_rst ? yuv_rgb_conv_pkg::MODE_RESET : nxt_mode;
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    sequence take_s; pix_valid && pix_ready; endsequence
    sequence hold_s; !pix_ready [*2]; endsequence
    req_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus request not answered next cycle");
    ack_width_a: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
        else $error("waitrequest low longer than one cycle");
    idle_wait_a: assert property (!avs_waitrequest |-> avs_read || avs_write)
        else $error("waitrequest low without request");
    unmapped_zero_a: assert property (rd_done && !mapped |-> avs_readdata == 32'h00000000)
        else $error("unmapped read not zero");
    upper_zero_a: assert property (rd_done |-> avs_readdata[31:16] == 16'h0000)
        else $error("upper read bits not zero");
    mode_readback_a: assert property (rd_mode |-> avs_readdata[15:0] == (mode_ff & 16'hFD77))
        else $error("mode register readback wrong");
    reserved_zero_a: assert property (rd_mode |-> !avs_readdata[7])
        else $error("reserved mode bit reads one");
    conv_hold_a: assert property ((mode_ff[14]) [*2] |-> !pix_ready && !mem_valid)
        else $error("converter active while held in reset");
    pair_take_a: assert property (take_s |=> hold_s)
        else $error("pair accepted too soon after previous");
    // Converter reset flushes the queue, so a held word may vanish then
    out_hold_a: assert property (mem_valid && !mem_ready && !mode_ff[14] |=> mem_valid && $stable(mem_data))
        else $error("output word changed before taken");
endmodule

// file: testbench/pix_source.sv
`timescale 1ns/1ps
module pix_source (
    input wire logic                       core_clk,  // Clock
    input wire logic                       pix_ready, // Pair taken
    output logic                           pix_valid, // Pair offered
    output yuv_rgb_conv_pkg::yuv_pair_type pix_data   // Pair
);
    initial
    begin
        pix_valid = 1'b0;
        pix_data  = '0;
    end
    // Extra edge keeps valid from being set twice in one step
    task automatic send(input yuv_rgb_conv_pkg::yuv_pair_type d, input int gap);
        repeat (gap + 1) @(posedge core_clk);
        pix_valid <= 1'b1;
        pix_data  <= d;
        do @(posedge core_clk); while (pix_ready !== 1'b1);
        pix_valid <= 1'b0;
        // Released bus shows no stale pair
        pix_data  <= ~d;
    endtask
endmodule

// file: testbench/tb_yuv_rgb_conv_ctrl.sv
`timescale 1ns/1ps
module tb_yuv_rgb_conv_ctrl;
    logic                           core_clk, sys_rst, avs_read, avs_write, avs_waitrequest;
    logic                           pix_valid, pix_ready, mem_valid, mem_ready, stall;
    logic [11:0]                    avs_address;
    logic [31:0]                    avs_writedata, avs_readdata, rd;
    logic [3:0]                     avs_byteenable;
    logic [15:0]                    mem_data, mode, fx;
    logic [15:0]                    exp_q[$];
    yuv_rgb_conv_pkg::yuv_pair_type pix_data, pr;
    int                             n_errors, tests_run;

    yuv_rgb_conv_ctrl i_dut (.core_clk(core_clk), .sys_rst(sys_rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .pix_valid(pix_valid), .pix_ready(pix_ready), .pix_data(pix_data),
        .mem_valid(mem_valid), .mem_ready(mem_ready), .mem_data(mem_data));
    pix_source i_src (.core_clk(core_clk), .pix_ready(pix_ready), .pix_valid(pix_valid), .pix_data(pix_data));

    initial
    begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        tests_run++;
        if (seen !== want)
        begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic bus(input logic wr, input logic [11:0] a, input logic [15:0] d);
        @(posedge core_clk);
        avs_address   <= a;
        avs_read      <= !wr;
        avs_write     <= wr;
        avs_writedata <= {16'h0000, d};
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic setmode(input logic [15:0] m);
        mode = m;
        bus(1'b1, yuv_rgb_conv_pkg::ADDR_MODE, m);
    endtask

    // Luma-only colour is exact only with both chroma forced to mid scale
    function automatic logic [15:0] rgb(input logic [7:0] y);
        return {y[7:3], y[7:2], y[7:3]};
    endfunction

    task automatic pair(input int gap);
        logic [7:0] u;
        logic [7:0] v;
        pr = $urandom;
        u = mode[12] ? fx[15:8] : pr.u;
        v = mode[13] ? fx[7:0] : pr.v;
        if (!mode[15])
        begin
            exp_q.push_back(rgb(pr.y0));
            exp_q.push_back(rgb(pr.y1));
        end
        else if (mode[8])
        begin
            exp_q.push_back({pr.y0, u});
            exp_q.push_back({pr.y1, v});
        end
        else
        begin
            exp_q.push_back({v, pr.y1});
            exp_q.push_back({u, pr.y0});
        end
        i_src.send(pr, gap);
    endtask

    always @(posedge core_clk)
    begin
        if (mem_valid === 1'b1 && mem_ready === 1'b1)
            check(mem_data, (exp_q.size() > 0) ? exp_q.pop_front() : 32'h00010000);
        mem_ready <= !stall && ($urandom % 4 != 0);
    end

    initial
    begin
        repeat (20000) @(posedge core_clk);
        n_errors++;
        complete_run();
    end

    initial
    begin
        {sys_rst, avs_read, avs_write, stall, mem_ready} = 5'b10000;
        {avs_address, avs_writedata, avs_byteenable} = {12'h000, 32'h00000000, 4'h3};
        {n_errors, tests_run, mode, fx} = 0;
        void'($urandom(32'h385ED1C3));
        repeat (5) @(posedge core_clk);
        sys_rst <= 1'b0;
        bus(1'b0, yuv_rgb_conv_pkg::ADDR_MODE, 16'h0000);
        check(rd, 32'h00000405);
        bus(1'b0, yuv_rgb_conv_pkg::ADDR_FIXED, 16'h0000);
        check(rd, 32'h00000000);
        bus(1'b0, 12'h004, 16'h0000);
        check(rd, 32'h00000000);
        // Only the low lane enabled: upper byte must keep its reset value
        avs_byteenable <= 4'h1;
        bus(1'b1, yuv_rgb_conv_pkg::ADDR_FIXED, 16'hFFFF);
        avs_byteenable <= 4'h3;
        bus(1'b0, yuv_rgb_conv_pkg::ADDR_FIXED, 16'h0000);
        check(rd, 32'h000000FF);
        setmode(16'h8080);
        bus(1'b0, yuv_rgb_conv_pkg::ADDR_MODE, 16'h0000);
        check(rd, 32'h00008000);
        repeat (3) pair($urandom % 3);
        setmode(16'h8100);
        repeat (3) pair($urandom % 3);
        fx = $urandom;
        bus(1'b1, yuv_rgb_conv_pkg::ADDR_FIXED, fx);
        for (int f = 1; f < 4; f++)
        begin
            setmode(16'(32'h8000 | (f << 12) | ((f & 1) << 8)));
            pair(1);
            pair(0);
        end
        fx = 16'h8080;
        bus(1'b1, yuv_rgb_conv_pkg::ADDR_FIXED, fx);
        for (int d = 0; d < 4; d++)
        begin
            setmode(16'(32'h3000 | (d << 10) | ((d & 1) << 8)));
            pair(0);
            pair(2);
        end
        // Flushing drops queued words, so drain first
        while (exp_q.size() != 0) @(posedge core_clk);
        setmode(mode | 16'h4000);
        repeat (4) @(posedge core_clk);
        check(pix_ready, 32'h0);
        bus(1'b0, yuv_rgb_conv_pkg::ADDR_STATUS, 16'h0000);
        check(rd, 32'h00000100);
        bus(1'b0, yuv_rgb_conv_pkg::ADDR_MODE, 16'h0000);
        check(rd, {16'h0000, mode & 16'hFD77});
        setmode(mode & ~16'h4000);
        pair(0);
        while (exp_q.size() != 0) @(posedge core_clk);
        setmode(16'h8000);
        stall <= 1'b1;
        fork
            repeat (6) pair(0);
            begin
                repeat (80) @(posedge core_clk);
                check(pix_ready, 32'h0);
                check(mem_valid, 32'h1);
                // Queue full, formatter stuck on its second word
                bus(1'b0, yuv_rgb_conv_pkg::ADDR_STATUS, 16'h0000);
                check(rd, 32'h00000408);
                stall <= 1'b0;
            end
        join
        while (exp_q.size() != 0) @(posedge core_clk);
        complete_run();
    end
endmodule

bind yuv_rgb_conv_ctrl conv_ctrl_checker i_chk (.core_clk(core_clk), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .pix_valid(pix_valid), .pix_ready(pix_ready), .mem_valid(mem_valid), .mem_ready(mem_ready),
    .mem_data(mem_data));
